// ---- verification/msc_stats_assertions.sv ----
// bus and counter checks for the mac statistics block
`timescale 1ns/1ps
`default_nettype none
module msc_chk
  import msc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_RST_IDLE: assert property (
    $rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid && s_axi_arready)
    else $error("bus busy after reset");
  AST_R_LAT: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_R_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  AST_B_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  AST_AW_BUSY: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && !s_axi_bvalid
      |=> !s_axi_awready ##1 s_axi_awready && s_axi_bvalid)
    else $error("write address ready too soon");
  AST_B_LAT: assert property (
    $rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready, 2)
      || $past(s_axi_wvalid && s_axi_wready, 2))
    else $error("write response timing");
  AST_CTR_WR: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == MSC_OFS_TX_FRM
      |-> ##2 s_axi_bvalid && s_axi_bresp == MSC_RESP_SLVERR)
    else $error("counter write not refused");
  AST_UNMAP: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h004
      |=> s_axi_rresp == MSC_RESP_DECERR && s_axi_rdata == MSC_RDATA_RST)
    else $error("unmapped read answer");
endmodule
bind msc_stats msc_chk msc_chk_i (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the mac statistics block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
  err_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
  import msc_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] m [5];
  logic [11:0] ofs [5] = '{MSC_OFS_RX_ALL, MSC_OFS_RX_OK, MSC_OFS_TX_FRM,
                           MSC_OFS_TX_BYTE, MSC_OFS_TX_BOK};
  int          err_count = 0, comparisons = 0, cyc = 0;
  int          tally [5] = '{default: 0};
  logic [31:0] st [5], last_rd;
  msc_stats msc_stats_i (.aclk, .aresetn, .rx_frame_total(ev[0]),
    .rx_valid_frame_total(ev[1]), .tx_frame_total(ev[2]),
    .tx_byte_total(ev[3]), .tx_valid_byte_total(ev[4]), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  always #50 aclk = ~aclk;
  // counter model and run limit
  always @(posedge aclk)
  begin
    cyc++;
    for (int i = 0; i < 5; i++)
      if (!aresetn)
        m[i] = 32'h0;
      else
        m[i] += ev[i];
    if (cyc == 5000)
    begin
      err_count++;
      end_of_test();
    end
  end
  function automatic logic [31:0] lane(input logic [31:0] v,
                                       input logic sw);
    return sw ? v : {v[7:0], v[15:8], v[23:16], v[31:24]};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($urandom);
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    `CHK("bresp", er, s_axi_bresp)
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom);
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
    last_rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdall(input logic sw);
    for (int i = 0; i < 5; i++)
      rd(ofs[i], lane(m[i], sw), MSC_RESP_OKAY);
  endtask
  task automatic burst(input int n);
    logic [4:0] v;
    repeat (n)
    begin
      v = 5'($urandom);
      ev <= v;
      for (int i = 0; i < 5; i++)
        tally[i] += int'(v[i]);
      @(posedge aclk);
    end
    ev <= 5'h00;
    @(posedge aclk);
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h63e17985));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdall(1'b0);
    rd(MSC_OFS_CTRL, 32'h0, MSC_RESP_OKAY);
    burst(300);
    rdall(1'b0);
    rdall(1'b0);
    wr(MSC_OFS_TX_FRM, 32'hffffffff, MSC_RESP_SLVERR);
    rd(12'h004, 32'h0, MSC_RESP_DECERR);
    wr(12'h004, 32'h0, MSC_RESP_DECERR);
    wr(MSC_OFS_CTRL, 32'h1, MSC_RESP_OKAY);
    rd(MSC_OFS_CTRL, 32'h1, MSC_RESP_OKAY);
    // control write without lane 0 leaves swap set
    s_axi_wstrb <= 4'he;
    wr(MSC_OFS_CTRL, 32'h0, MSC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(MSC_OFS_CTRL, 32'h1, MSC_RESP_OKAY);
    // start values of a short measurement interval
    for (int i = 0; i < 5; i++)
    begin
      rd(ofs[i], lane(m[i], 1'b1), MSC_RESP_OKAY);
      st[i] = last_rd;
      tally[i] = 0;
    end
    burst(40);
    for (int i = 0; i < 5; i++)
    begin
      rd(ofs[i], lane(m[i], 1'b1), MSC_RESP_OKAY);
      `CHK("delta", 32'(tally[i]), last_rd - st[i])
    end
    aresetn <= 1'b0;
    ev <= 5'h1f;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    ev <= 5'h00;
    rdall(1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- verilog/msc_cnt_if.sv ----
// increment and count carrier between the top and one counter
`timescale 1ns/1ps
`default_nettype none
interface msc_cnt_if;
  logic        inc;
  logic [31:0] count;
  modport src (output inc, input count);
  modport cnt (input inc, output count);
endinterface
`default_nettype wire

// ---- verilog/msc_counter.sv ----
// one 32-bit wrapping statistics counter
`timescale 1ns/1ps
`default_nettype none
module msc_counter
  import msc_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  msc_cnt_if.cnt    port
);
  typedef struct packed
  {
    logic [31:0] count;
  } msc_ctr_s;

  msc_ctr_s state_r;
  msc_ctr_s state_nxt;

  always_comb
  begin
    state_nxt = state_r;
    // wraps to zero past all ones, never holds
    if (port.inc)
    begin
      state_nxt.count = state_r.count + MSC_CNT_ONE;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r.count <= MSC_CNT_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign port.count = state_r.count;
endmodule
`default_nettype wire

// ---- verilog/msc_pkg.sv ----
// constants for the mac statistics counter block
package msc_pkg;
  localparam int          MSC_ADDR_W        = 12;
  localparam int          MSC_DATA_W        = 32;
  localparam int          MSC_NUM_CNT       = 5;
  // counter slots
  localparam int          MSC_IDX_RX_ALL    = 0;
  localparam int          MSC_IDX_RX_OK     = 1;
  localparam int          MSC_IDX_TX_FRM    = 2;
  localparam int          MSC_IDX_TX_BYTE   = 3;
  localparam int          MSC_IDX_TX_BOK    = 4;
  // byte addresses
  localparam logic [11:0] MSC_OFS_CTRL      = 12'h000;
  localparam logic [11:0] MSC_OFS_RX_ALL    = 12'h200;
  localparam logic [11:0] MSC_OFS_RX_OK     = 12'h204;
  localparam logic [11:0] MSC_OFS_TX_FRM    = 12'h300;
  localparam logic [11:0] MSC_OFS_TX_BYTE   = 12'h308;
  localparam logic [11:0] MSC_OFS_TX_BOK    = 12'h30c;
  // control register fields, counter and read data constants
  localparam int          MSC_CTRL_SWAP_BIT = 0;
  localparam logic        MSC_CTRL_RST      = 1'h0;
  localparam logic [31:0] MSC_CNT_RST       = 32'h00000000;
  localparam logic [31:0] MSC_CNT_ONE       = 32'h00000001;
  localparam logic [31:0] MSC_RDATA_RST     = 32'h00000000;
  // axi responses
  localparam logic [1:0]  MSC_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  MSC_RESP_SLVERR   = 2'h2;
  localparam logic [1:0]  MSC_RESP_DECERR   = 2'h3;
endpackage

// ---- verilog/msc_stats.sv ----
// mac statistics counters with an axi4-lite register slave
// Function
// - every received frame, valid or not, adds one to the rx total.
// - only a received frame judged valid adds one to the rx valid count.
// - every transmitted frame adds one to the tx frame total.
// - every transmitted byte adds one to the tx byte total.
// - counters clear only on reset; reads and writes leave them alone.
// - a counter past all ones wraps to zero and never saturates.
// - unless swap is set, the lowest byte of a counter word holds bits 31 to 24.
// - each valid transmitted byte adds one to the tx valid byte count.
`timescale 1ns/1ps
`default_nettype none
module msc_stats
  import msc_pkg::*;
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // mac event pulses, one cycle per event
  input  wire logic                      rx_frame_total,
  input  wire logic                      rx_valid_frame_total,
  input  wire logic                      tx_frame_total,
  input  wire logic                      tx_byte_total,
  input  wire logic                      tx_valid_byte_total,
  // axi4-lite slave
  input  wire logic [msc_pkg::MSC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [msc_pkg::MSC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  typedef struct packed
  {
    logic                  awready;
    logic                  aw_got;
    logic [MSC_ADDR_W-1:0] aw_addr;
    logic                  wready;
    logic                  w_got;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
    logic                  swap;
  } msc_top_s;

  msc_top_s state_r;
  msc_top_s state_nxt;

  logic [MSC_NUM_CNT-1:0] events;
  logic [31:0]            counts [MSC_NUM_CNT];

  msc_cnt_if cif [MSC_NUM_CNT] ();

  assign events[MSC_IDX_RX_ALL]  = rx_frame_total;
  assign events[MSC_IDX_RX_OK]   = rx_valid_frame_total;
  assign events[MSC_IDX_TX_FRM]  = tx_frame_total;
  assign events[MSC_IDX_TX_BYTE] = tx_byte_total;
  assign events[MSC_IDX_TX_BOK]  = tx_valid_byte_total;

  genvar gi;
  generate
    for (gi = 0; gi < MSC_NUM_CNT; gi++)
    begin : g_cnt
      assign cif[gi].inc = events[gi];
      assign counts[gi]  = cif[gi].count;
      msc_counter u_cnt
      (
        .aclk    (aclk),
        .aresetn (aresetn),
        .port    (cif[gi])
      );
    end
  endgenerate

  // word-aligned decode of a counter address
  function automatic logic [3:0] cnt_slot(input logic [MSC_ADDR_W-1:0] a);
    logic [11:0] wa;
    wa = {a[11:2], 2'h0};
    case (wa)
      MSC_OFS_RX_ALL:  cnt_slot = 4'(MSC_IDX_RX_ALL);
      MSC_OFS_RX_OK:   cnt_slot = 4'(MSC_IDX_RX_OK);
      MSC_OFS_TX_FRM:  cnt_slot = 4'(MSC_IDX_TX_FRM);
      MSC_OFS_TX_BYTE: cnt_slot = 4'(MSC_IDX_TX_BYTE);
      MSC_OFS_TX_BOK:  cnt_slot = 4'(MSC_IDX_TX_BOK);
      default:         cnt_slot = 4'hf;
    endcase
  endfunction

  function automatic logic is_ctrl(input logic [MSC_ADDR_W-1:0] a);
    is_ctrl = ({a[11:2], 2'h0} == MSC_OFS_CTRL);
  endfunction

  // msb of the count in the lowest byte lane unless swap is set
  function automatic logic [31:0] lane_map(input logic [31:0] v,
                                           input logic        sw);
    if (sw)
    begin
      lane_map = v;
    end
    else
    begin
      lane_map = {v[7:0], v[15:8], v[23:16], v[31:24]};
    end
  endfunction

  logic [3:0]  rd_slot;
  logic [31:0] rd_word;

  always_comb
  begin
    rd_slot = cnt_slot(s_axi_araddr);
    rd_word = MSC_RDATA_RST;
    if (rd_slot < 4'(MSC_NUM_CNT))
    begin
      rd_word = counts[rd_slot[2:0]];
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    // write address and data, in either order
    if (s_axi_awvalid && state_r.awready)
    begin
      state_nxt.aw_got  = 1'b1;
      state_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_r.wready)
    begin
      state_nxt.w_got  = 1'b1;
      state_nxt.w_data = s_axi_wdata;
      state_nxt.w_strb = s_axi_wstrb;
    end
    if (state_r.bvalid && s_axi_bready)
    begin
      state_nxt.bvalid = 1'b0;
    end
    // counters ignore writes, only control is writable
    if (state_r.aw_got && state_r.w_got && !state_r.bvalid)
    begin
      state_nxt.aw_got = 1'b0;
      state_nxt.w_got  = 1'b0;
      state_nxt.bvalid = 1'b1;
      if (is_ctrl(state_r.aw_addr))
      begin
        state_nxt.bresp = MSC_RESP_OKAY;
        if (state_r.w_strb[0])
        begin
          state_nxt.swap = state_r.w_data[MSC_CTRL_SWAP_BIT];
        end
      end
      else if (cnt_slot(state_r.aw_addr) != 4'hf)
      begin
        state_nxt.bresp = MSC_RESP_SLVERR;
      end
      else
      begin
        state_nxt.bresp = MSC_RESP_DECERR;
      end
    end
    state_nxt.awready = !state_nxt.aw_got;
    state_nxt.wready  = !state_nxt.w_got;
    // read channel, whole word captured in one edge
    if (state_r.rvalid && s_axi_rready)
    begin
      state_nxt.rvalid  = 1'b0;
      state_nxt.arready = 1'b1;
    end
    if (s_axi_arvalid && state_r.arready)
    begin
      state_nxt.arready = 1'b0;
      state_nxt.rvalid  = 1'b1;
      if (is_ctrl(s_axi_araddr))
      begin
        state_nxt.rdata = {31'h00000000, state_r.swap};
        state_nxt.rresp = MSC_RESP_OKAY;
      end
      else if (rd_slot != 4'hf)
      begin
        state_nxt.rdata = lane_map(rd_word, state_r.swap);
        state_nxt.rresp = MSC_RESP_OKAY;
      end
      else
      begin
        state_nxt.rdata = MSC_RDATA_RST;
        state_nxt.rresp = MSC_RESP_DECERR;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r         <= '0;
      state_r.awready <= 1'b1;
      state_r.wready  <= 1'b1;
      state_r.arready <= 1'b1;
      state_r.swap    <= MSC_CTRL_RST;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign s_axi_awready = state_r.awready;
  assign s_axi_wready  = state_r.wready;
  assign s_axi_bvalid  = state_r.bvalid;
  assign s_axi_bresp   = state_r.bresp;
  assign s_axi_arready = state_r.arready;
  assign s_axi_rvalid  = state_r.rvalid;
  assign s_axi_rdata   = state_r.rdata;
  assign s_axi_rresp   = state_r.rresp;
endmodule
`default_nettype wire
